// ==== hw/tmc_top.sv ====
// timer modulo compare, overflow and per-channel status/control with apb access
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module tmc_top
    import tmc_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic clock_in, // 10 mhz system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [7:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error on unmapped address
    input wire logic debug_halt_in, // processor in background debug
    input wire logic [NCH-1:0] chan_pin_in, // channel pin levels
    output logic [NCH-1:0] chan_pin_out, // channel pin drive value
    output logic [NCH-1:0] chan_pin_oe_out, // channel owns the pin
    output logic [NCH-1:0] chan_irq_out, // channel interrupt request
    output logic overflow_irq_out // overflow interrupt request
);
    localparam int AW = (NCH > 1) ? $clog2(NCH) : 1;

    logic [15:0] modulo;
    logic [15:0] count;
    logic count_down;
    logic mod_low_pend;
    logic mod_high_pend;
    logic overflow_flag;
    logic ovf_armed;
    logic ovf_irq_enable;
    logic center_pwm_select;
    logic timer_run;
    logic [7:0] count_latch_high;
    logic count_latched;
    logic [NCH-1:0] channel_event_flag;
    logic [NCH-1:0] clear_armed;
    logic [NCH-1:0] channel_irq_enable;
    logic [NCH-1:0] mode_select_high;
    logic [NCH-1:0] mode_select_low;
    logic [1:0] edge_level_select [NCH];
    logic [NCH-1:0] pin_prev;
    logic [NCH-1:0] chan_event;
    logic [15:0] chan_value [NCH];
    logic [AW-1:0] rd_idx;
    logic [15:0] mem_rd_data;

    wire access = psel_in && penable_in && !pready_out; // a second access cycle must not repeat side effects
    wire wr = access && pwrite_in;
    wire rd = access && !pwrite_in;
    wire tick = timer_run && !debug_halt_in;
    wire [15:0] terminal = (modulo == MOD_RESET) ? COUNT_FULL : modulo;
    wire at_terminal = (count == terminal);
    wire turn_point = center_pwm_select ? (count_down && count == COUNT_ZERO) : at_terminal;
    wire ovf_event = tick && (center_pwm_select ? (!count_down && at_terminal) : at_terminal);
    wire mod_pending = mod_low_pend || mod_high_pend;

    function automatic logic is_chan(input logic [7:0] a, input logic [7:0] base);
        is_chan = (a >= base) && (a < base + 8'(4 * NCH)) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [AW-1:0] chan_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] off;
        off = a - base;
        chan_idx = off[AW+1:2];
    endfunction

    function automatic tmc_mode_t chan_mode(input logic cpwm, input logic msb, input logic msa);
        if (cpwm) begin
            chan_mode = TMC_CPWM;
        end else if (msb) begin
            chan_mode = TMC_EPWM;
        end else if (msa) begin
            chan_mode = TMC_COMPARE;
        end else begin
            chan_mode = TMC_CAPTURE;
        end
    endfunction

    wire mapped = (paddr_in == ADDR_MOD_LOW) || (paddr_in == ADDR_MOD_HIGH) || (paddr_in == ADDR_TIMER_CTRL) ||
        (paddr_in == ADDR_COUNT_LOW) || (paddr_in == ADDR_COUNT_HIGH) ||
        is_chan(paddr_in, ADDR_CHAN_BASE) || is_chan(paddr_in, ADDR_CHAN_VAL_BASE);

    // counter: up count or up/down in center mode, frozen in debug
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count <= COUNT_ZERO;
            count_down <= 1'b0;
        end else if (wr && (paddr_in == ADDR_COUNT_LOW || paddr_in == ADDR_COUNT_HIGH)) begin
            count <= COUNT_ZERO;
            count_down <= 1'b0;
        end else if (tick) begin
            if (center_pwm_select) begin
                if (!count_down && at_terminal) begin
                    count_down <= 1'b1;
                    count <= count - 16'h0001;
                end else if (count_down && count == COUNT_ZERO) begin
                    count_down <= 1'b0;
                    count <= count + 16'h0001;
                end else begin
                    count <= count_down ? count - 16'h0001 : count + 16'h0001;
                end
            end else begin
                count_down <= 1'b0;
                count <= at_terminal ? COUNT_ZERO : count + 16'h0001;
            end
        end
    end

    // modulo bytes with split-write suppression
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            modulo <= MOD_RESET;
            mod_low_pend <= 1'b0;
            mod_high_pend <= 1'b0;
        end else if (wr && paddr_in == ADDR_MOD_LOW) begin
            modulo[7:0] <= pwdata_in[7:0];
            mod_low_pend <= !mod_high_pend;
            mod_high_pend <= 1'b0;
        end else if (wr && paddr_in == ADDR_MOD_HIGH) begin
            modulo[15:8] <= pwdata_in[7:0];
            mod_high_pend <= !mod_low_pend;
            mod_low_pend <= 1'b0;
        end
    end

    // timer control and overflow flag, set wins over the clearing write
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_flag <= 1'b0;
            ovf_armed <= 1'b0;
            ovf_irq_enable <= 1'b0;
            center_pwm_select <= 1'b0;
            timer_run <= 1'b0;
        end else begin
            if (ovf_event && !mod_pending) begin
                overflow_flag <= 1'b1;
                ovf_armed <= 1'b0;
            end else if (wr && paddr_in == ADDR_TIMER_CTRL) begin
                if (ovf_armed && !pwdata_in[TCTRL_OVF_BIT]) begin
                    overflow_flag <= 1'b0;
                end
                ovf_armed <= 1'b0;
            end else if (rd && paddr_in == ADDR_TIMER_CTRL && overflow_flag) begin
                ovf_armed <= 1'b1;
            end
            if (wr && paddr_in == ADDR_TIMER_CTRL) begin
                ovf_irq_enable <= pwdata_in[TCTRL_OVF_IE_BIT];
                center_pwm_select <= pwdata_in[TCTRL_CPWM_BIT];
                timer_run <= pwdata_in[TCTRL_RUN_BIT];
            end
        end
    end

    // byte coherency latch for counter reads, frozen while halted
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_latch_high <= 8'h00;
            count_latched <= 1'b0;
        end else if (wr && (paddr_in == ADDR_COUNT_LOW || paddr_in == ADDR_COUNT_HIGH ||
                            paddr_in == ADDR_TIMER_CTRL)) begin
            count_latched <= 1'b0;
        end else if (rd && paddr_in == ADDR_COUNT_LOW && !debug_halt_in) begin
            count_latch_high <= count[15:8];
            count_latched <= 1'b1;
        end else if (rd && paddr_in == ADDR_COUNT_HIGH && !debug_halt_in) begin
            count_latched <= 1'b0;
        end
    end

    // per-channel event detection and status/control
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_chan
            tmc_mode_t mode;
            wire rise = chan_pin_in[g] && !pin_prev[g];
            wire fall = !chan_pin_in[g] && pin_prev[g];
            wire csc_hit = (paddr_in == ADDR_CHAN_BASE + 8'(4 * g));
            assign mode = chan_mode(center_pwm_select, mode_select_high[g], mode_select_low[g]);
            always_comb begin
                chan_event[g] = 1'b0;
                if (mode == TMC_CAPTURE) begin
                    case (edge_level_select[g])
                        ELS_01: chan_event[g] = rise;
                        ELS_10: chan_event[g] = fall;
                        ELS_11: chan_event[g] = rise || fall;
                        default: chan_event[g] = 1'b0;
                    endcase
                end else begin
                    chan_event[g] = tick && (count == chan_value[g]);
                end
            end

            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    pin_prev[g] <= 1'b0;
                end else begin
                    pin_prev[g] <= chan_pin_in[g];
                end
            end

            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    channel_event_flag[g] <= 1'b0;
                    clear_armed[g] <= 1'b0;
                    channel_irq_enable[g] <= 1'b0;
                    mode_select_high[g] <= 1'b0;
                    mode_select_low[g] <= 1'b0;
                    edge_level_select[g] <= ELS_NONE;
                end else begin
                    if (chan_event[g]) begin
                        channel_event_flag[g] <= 1'b1;
                        clear_armed[g] <= 1'b0;
                    end else if (wr && csc_hit) begin
                        if (clear_armed[g] && !pwdata_in[FLAG_BIT]) begin
                            channel_event_flag[g] <= 1'b0;
                        end
                        clear_armed[g] <= 1'b0;
                    end else if (rd && csc_hit && channel_event_flag[g]) begin
                        clear_armed[g] <= 1'b1;
                    end
                    if (wr && csc_hit) begin
                        channel_irq_enable[g] <= pwdata_in[IRQ_EN_BIT];
                        mode_select_high[g] <= pwdata_in[MODE_HIGH_BIT];
                        mode_select_low[g] <= pwdata_in[MODE_LOW_BIT];
                        edge_level_select[g] <= pwdata_in[ELS_HIGH_BIT:ELS_LOW_BIT];
                    end
                end
            end

            // pin drive: compare actions and pwm polarity
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    chan_pin_out[g] <= 1'b0;
                    chan_pin_oe_out[g] <= 1'b0;
                end else begin
                    chan_pin_oe_out[g] <= (edge_level_select[g] != ELS_NONE) && (mode != TMC_CAPTURE);
                    if (mode == TMC_COMPARE && chan_event[g]) begin
                        case (edge_level_select[g])
                            ELS_01: chan_pin_out[g] <= !chan_pin_out[g];
                            ELS_10: chan_pin_out[g] <= 1'b0;
                            ELS_11: chan_pin_out[g] <= 1'b1;
                            default: chan_pin_out[g] <= chan_pin_out[g];
                        endcase
                    end else if (mode == TMC_EPWM) begin
                        if (chan_event[g]) begin
                            chan_pin_out[g] <= edge_level_select[g][0];
                        end else if (tick && count == terminal) begin
                            chan_pin_out[g] <= !edge_level_select[g][0];
                        end
                    end else if (mode == TMC_CPWM) begin
                        if (chan_event[g]) begin
                            chan_pin_out[g] <= count_down ? !edge_level_select[g][0] : edge_level_select[g][0];
                        end
                    end
                end
            end

            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    chan_irq_out[g] <= 1'b0;
                end else begin
                    chan_irq_out[g] <= channel_event_flag[g] && channel_irq_enable[g];
                end
            end
        end
    endgenerate

    // channel value store; read data registered from the setup-phase address, so reads answer with the same timing as other registers
    assign rd_idx = chan_idx(paddr_in, ADDR_CHAN_VAL_BASE);
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NCH; i++) begin
                chan_value[i] <= COUNT_ZERO;
            end
        end else if (wr && is_chan(paddr_in, ADDR_CHAN_VAL_BASE)) begin
            chan_value[rd_idx] <= pwdata_in[15:0];
        end
    end

    tmc_chan_mem #(.DEPTH(NCH), .AW(AW)) u_mem (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .wr_en_in(wr && is_chan(paddr_in, ADDR_CHAN_VAL_BASE)),
        .wr_addr_in(rd_idx),
        .wr_data_in(pwdata_in[15:0]),
        .rd_addr_in(rd_idx),
        .rd_data_out(mem_rd_data)
    );

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overflow_irq_out <= 1'b0;
        end else begin
            overflow_irq_out <= overflow_flag && ovf_irq_enable;
        end
    end

    // apb: every access takes two cycles in the access phase (wait then ready)
    logic [NCH-1:0] csc_sel;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            csc_sel[i] = (paddr_in == ADDR_CHAN_BASE + 8'(4 * i));
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else if (psel_in && penable_in && !pready_out) begin
            pready_out <= 1'b1;
            pslverr_out <= !mapped;
            prdata_out <= 32'h0000_0000;
            if (!pwrite_in) begin
                if (paddr_in == ADDR_MOD_LOW) begin
                    prdata_out[7:0] <= modulo[7:0];
                end else if (paddr_in == ADDR_MOD_HIGH) begin
                    prdata_out[7:0] <= modulo[15:8];
                end else if (paddr_in == ADDR_TIMER_CTRL) begin
                    prdata_out[7:0] <= {overflow_flag, ovf_irq_enable, center_pwm_select, 4'h0, timer_run};
                end else if (paddr_in == ADDR_COUNT_LOW) begin
                    prdata_out[7:0] <= count[7:0];
                end else if (paddr_in == ADDR_COUNT_HIGH) begin
                    prdata_out[7:0] <= count_latched ? count_latch_high : count[15:8];
                end else if (is_chan(paddr_in, ADDR_CHAN_VAL_BASE)) begin
                    prdata_out[15:0] <= mem_rd_data;
                end else begin
                    for (int i = 0; i < NCH; i++) begin
                        if (csc_sel[i]) begin
                            prdata_out[7:0] <= {channel_event_flag[i], channel_irq_enable[i], mode_select_high[i],
                                                mode_select_low[i], edge_level_select[i], 2'b00};
                        end
                    end
                end
            end
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== hw/tmc_pkg.sv ====
// package of register map, field positions and mode codes for the timer modulo/channel block
package tmc_pkg;
    localparam logic [7:0] ADDR_MOD_LOW = 8'h00;
    localparam logic [7:0] ADDR_MOD_HIGH = 8'h04;
    localparam logic [7:0] ADDR_TIMER_CTRL = 8'h08;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'h0c;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'h10;
    localparam logic [7:0] ADDR_CHAN_BASE = 8'h20;
    localparam logic [7:0] ADDR_CHAN_VAL_BASE = 8'h40;
    localparam logic [15:0] MOD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_FULL = 16'hffff;
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int MODE_HIGH_BIT = 5;
    localparam int MODE_LOW_BIT = 4;
    localparam int ELS_HIGH_BIT = 3;
    localparam int ELS_LOW_BIT = 2;
    localparam int TCTRL_OVF_BIT = 7;
    localparam int TCTRL_OVF_IE_BIT = 6;
    localparam int TCTRL_CPWM_BIT = 5;
    localparam int TCTRL_RUN_BIT = 0;
    localparam logic [1:0] ELS_NONE = 2'b00;
    localparam logic [1:0] ELS_01 = 2'b01;
    localparam logic [1:0] ELS_10 = 2'b10;
    localparam logic [1:0] ELS_11 = 2'b11;
    typedef enum logic [1:0] {
        TMC_CAPTURE = 2'b00,
        TMC_COMPARE = 2'b01,
        TMC_EPWM = 2'b11,
        TMC_CPWM = 2'b10
    } tmc_mode_t;
endpackage

// ==== hw/tmc_chan_mem.sv ====
// small register file holding the per-channel compare values, registered read port
`timescale 1ns/10ps
`default_nettype none
module tmc_chan_mem
    import tmc_pkg::*;
#(
    parameter int DEPTH = 2,
    parameter int AW = 1
) (
    input wire logic clock_in, // system clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic wr_en_in, // write strobe
    input wire logic [AW-1:0] wr_addr_in, // write index
    input wire logic [15:0] wr_data_in, // write data
    input wire logic [AW-1:0] rd_addr_in, // read index
    output logic [15:0] rd_data_out // registered read data
);
    logic [15:0] mem [DEPTH];

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= COUNT_ZERO;
            end
        end else if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_out <= COUNT_ZERO;
        end else begin
            rd_data_out <= mem[rd_addr_in];
        end
    end
endmodule
`default_nettype wire

// ==== verif/tmc_chk.sv ====
// port-level assertion checker for the timer modulo/channel block
`timescale 1ns/10ps
`default_nettype none
module tmc_chk #(
    parameter int NCH = 2
) (
    input wire logic clock_in, // clock
    input wire logic rst_n_in, // reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [31:0] prdata_out, // apb read data
    input wire logic pready_out, // apb ready
    input wire logic pslverr_out, // apb error
    input wire logic debug_halt_in, // debug freeze
    input wire logic [NCH-1:0] chan_pin_oe_out, // pin ownership
    input wire logic [NCH-1:0] chan_irq_out, // channel requests
    input wire logic overflow_irq_out // overflow request
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic acc;
    // config changes and channel 0 request drops only ever follow a write access phase
    assign acc = psel_in && penable_in && pwrite_in;
    AST_ACCESS_ANSWER: assert property (psel_in && penable_in && !pready_out |-> ##1 pready_out)
        else $error("no ready one cycle after access");
    AST_READY_PULSE: assert property (pready_out |=> !pready_out)
        else $error("ready stood longer than one cycle");
    AST_READY_CAUSE: assert property ($rose(pready_out) |-> $past(psel_in && penable_in))
        else $error("ready without an access phase");
    AST_ERR_QUIET: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0000_0000)
        else $error("error response carries data");
    AST_RESET_QUIET: assert property ($rose(rst_n_in) |-> chan_irq_out == '0 && !overflow_irq_out)
        else $error("request active right after reset");
    AST_IRQ_DROP: assert property ($fell(chan_irq_out[0]) |-> $past(acc) || $past(acc, 2))
        else $error("channel request dropped without a write");
    AST_OE_BY_WRITE: assert property ($changed(chan_pin_oe_out) |-> $past(acc) || $past(acc, 2))
        else $error("pin ownership changed without a write");
    AST_HALT_NO_OVF: assert property ((debug_halt_in && !psel_in)[*4] |-> !$rose(overflow_irq_out))
        else $error("overflow while frozen");
    cover property ($rose(chan_irq_out[0]));
    cover property ($rose(overflow_irq_out));
    cover property (pslverr_out);
endmodule
bind tmc_top tmc_chk #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking testbench for the timer modulo/channel block
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import tmc_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, debug_halt_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
    logic pready_out, pslverr_out, overflow_irq_out, err;
    logic [1:0] chan_pin_in = 2'b00, chan_pin_out, chan_pin_oe_out, chan_irq_out;
    int miscompares = 0, check_count = 0;
    tmc_top #(.NCH(2)) dut (.*);
    always #50 clock_in = ~clock_in;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one edge of idle first, so psel is never assigned twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clock_in);
        penable_in <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clock_in);
            if (pready_out === 1'b1) begin
                rd = prdata_out;
                err = pslverr_out;
                psel_in <= 1'b0;
                penable_in <= 1'b0;
                return;
            end
        end
        miscompares++;
        close_out();
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic wait_hi(input logic ovf);
        for (int i = 0; i < 2000; i++) begin
            @(posedge clock_in);
            if ((ovf ? overflow_irq_out : chan_irq_out[0]) === 1'b1) begin
                return;
            end
        end
        miscompares++;
        close_out();
    endtask
    task automatic s_reset();
        rdchk(ADDR_MOD_LOW, 32'h0000_0000);
        rdchk(ADDR_MOD_HIGH, 32'h0000_0000);
        rdchk(ADDR_CHAN_BASE, 32'h0000_0000);
        rdchk(8'hfc, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
    endtask
    task automatic s_overflow();
        // modulo set while the counter is stopped at zero
        apb(1'b1, ADDR_MOD_LOW, 32'h0000_00ff);
        apb(1'b1, ADDR_MOD_HIGH, 32'h0000_0000);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h0000_0041);
        apb(1'b1, ADDR_COUNT_LOW, 32'h0000_0000);
        wait_hi(1'b1);
        rdchk(ADDR_TIMER_CTRL, 32'h0000_00c1);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h0000_0041);
        rdchk(ADDR_TIMER_CTRL, 32'h0000_0041);
        apb(1'b1, ADDR_MOD_LOW, 32'h0000_00ff);
        // longer than two periods, so a wrap has surely passed
        repeat (600) @(posedge clock_in);
        chk({31'h0, overflow_irq_out}, 32'h0000_0000);
        apb(1'b1, ADDR_MOD_HIGH, 32'h0000_0000);
        wait_hi(1'b1);
        rdchk(ADDR_COUNT_HIGH, 32'h0000_0000);
    endtask
    task automatic s_halt();
        logic [31:0] first;
        debug_halt_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        apb(1'b0, ADDR_COUNT_LOW, 32'h0000_0000);
        first = rd;
        repeat (20) @(posedge clock_in);
        rdchk(ADDR_COUNT_LOW, first);
        debug_halt_in <= 1'b0;
    endtask
    task automatic s_compare();
        apb(1'b1, ADDR_CHAN_VAL_BASE, 32'h0000_0080);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0054);
        wait_hi(1'b0);
        chk({30'h0, chan_pin_oe_out[0], chan_pin_out[0]}, 32'h0000_0003);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_00d4);
        rdchk(ADDR_CHAN_BASE, 32'h0000_00d4);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0054);
        repeat (2) @(posedge clock_in);
        chk({31'h0, chan_irq_out[0]}, 32'h0000_0000);
        wait_hi(1'b0);
        chk({31'h0, chan_pin_out[0]}, 32'h0000_0000);
        rdchk(ADDR_CHAN_BASE, 32'h0000_00d4);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0068);
        repeat (2) @(posedge clock_in);
        chk({31'h0, chan_irq_out[0]}, 32'h0000_0000);
        wait_hi(1'b0);
        chk({30'h0, chan_pin_oe_out[0], chan_pin_out[0]}, 32'h0000_0002);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0050);
        repeat (2) @(posedge clock_in);
        chk({31'h0, chan_pin_oe_out[0]}, 32'h0000_0000);
    endtask
    task automatic s_capture();
        for (int c = 1; c < 4; c++) begin
            apb(1'b1, ADDR_CHAN_BASE + 8'h04, 32'(c << 2));
            apb(1'b0, ADDR_CHAN_BASE + 8'h04, 32'h0000_0000);
            apb(1'b1, ADDR_CHAN_BASE + 8'h04, 32'(c << 2));
            chan_pin_in[1] <= 1'b1;
            repeat (4) @(posedge clock_in);
            rdchk(ADDR_CHAN_BASE + 8'h04, {24'h0, c[0], 3'h0, c[1:0], 2'h0});
            apb(1'b1, ADDR_CHAN_BASE + 8'h04, 32'(c << 2));
            chan_pin_in[1] <= 1'b0;
            repeat (4) @(posedge clock_in);
            rdchk(ADDR_CHAN_BASE + 8'h04, {24'h0, c[1], 3'h0, c[1:0], 2'h0});
        end
        // an edge between the arming read and the clearing write must keep the flag
        chan_pin_in[1] <= 1'b1;
        repeat (2) @(posedge clock_in);
        apb(1'b1, ADDR_CHAN_BASE + 8'h04, 32'h0000_000c);
        rdchk(ADDR_CHAN_BASE + 8'h04, 32'h0000_008c);
        chk({28'h0, chan_pin_oe_out, chan_irq_out}, 32'h0000_0001);
    endtask
    task automatic s_center();
        apb(1'b1, ADDR_COUNT_LOW, 32'h0000_0000);
        apb(1'b1, ADDR_TIMER_CTRL, 32'h0000_0061);
        rdchk(ADDR_CHAN_BASE, 32'h0000_00d0);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0044);
        wait_hi(1'b0);
        chk({30'h0, chan_pin_oe_out[0], chan_pin_out[0]}, 32'h0000_0003);
        rdchk(ADDR_CHAN_BASE, 32'h0000_00c4);
        apb(1'b1, ADDR_CHAN_BASE, 32'h0000_0044);
        wait_hi(1'b0);
        chk({31'h0, chan_pin_out[0]}, 32'h0000_0000);
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        rst_n_in <= 1'b1;
        s_reset();
        s_overflow();
        s_halt();
        s_compare();
        s_capture();
        s_center();
        close_out();
    end
endmodule
`default_nettype wire
